// >>> hdl/sensor_bus_protocol_config.sv
// Protocol configuration registers of the two-wire sensor bus interface
//
// How it works
// RULE1: Sampling bit 0 latency from time slot, 1 latency from sync pulse.
// RULE2: PSI5 timing code 0-7 gives 189 kHz, 8-15 gives 125 kHz, slew on.
// RULE3: DSI3 timing code picks chip time from table; slew off for codes 0, 1.
// RULE4: Fragment bit 0 gives 2 bits/3 chips, 1 gives 4 bits/6 chips.
// RULE5: Diagnostic enable switches diagnostic mode; both diag bits inert in PSI5 (code gates only the enable; fragment bit still sets diag_cmd_bits).
// RULE6: In PSI5 with pulldown bit set, pulldown engages after a sync pulse.
// RULE7: Chain bit 0 normal operation, 1 daisy chain; slot 0 sends first data.
// RULE8: In PSI5, current bit selects normal or reduced response current.
// RULE9: PSI5 clip range -102..+307, or -480..+480 when range bit set.
// RULE10: Error-detail bit 0 maps all errors to 1F4h, 1 uses extra codes.
// RULE11: PSI5 check bit selects even parity or 3-bit CRC; inert in DSI3.
// RULE12: Extension bit sends phase-2 fields D33 to D48; inert in DSI3.
// RULE13: Free-running transmit in PSI5 only when chain bit is clear.
// RULE14: Start values count 1 us steps; below 20 start at 20 us.
// RULE15: Start value zero transmits with a default 20 us start.
// RULE16: Source 0 uses slot 0 start pair, source 1 uses slot 1 pair.
// RULE17: Master must avoid start times that collide on the bus.
// RULE18: Registers accessible only in DSI3 mode or PSI5 diagnostic mode.
// RULE19: All registers here join the read/write array error check.
// RULE20: Broadcast selector 00/11 all reads, 01 read 0 only, 10 read 1 only.
// RULE21: Timing register holds code in bits 3-0, sampling select in bit 4.
// RULE22: Start value exactly 20 gives a 20 us start.
// RULE23: Start time is low register bits 7-0 plus high register bits 4-0.
`timescale 1ns/1ps
`include "sensor_cfg_params.svh"

module sensor_bus_protocol_config
   import sensor_cfg_pkg::*;
(
   input  wire logic      ref_clk,
   input  wire logic      rst_n,
   input  wire logic      psi5_mode,
   input  wire logic      psi5_diag_mode,
   input  wire logic      sync_pulse_seen,
   input  reg_req_t       reg_req,
   output reg_rsp_t       reg_rsp,
   output proto_settings_t settings,
   output slot_timing_t   slot0_timing,
   output slot_timing_t   slot1_timing,
   output logic           sync_pulldown_on,
   output logic           array_error
);

   logic [4:0] timing_config_reg;
   logic [1:0] diag_mode_config_reg;
   logic [7:0] bus_option_config_reg;
   logic [7:0] slot0_start_low_reg;
   logic [7:0] slot0_start_high_reg;
   logic [7:0] slot1_start_low_reg;
   logic [7:0] slot1_start_high_reg;
   logic [7:0] signature_reg;
   logic [7:0] signature_next;
   logic       access_open;
   logic       write_prev_reg;
   logic       addr_mapped;
   logic       do_write;
   logic [7:0] read_value;
   logic [3:0] code;

   // Tenths of a microsecond per DSI3 chip for each timing code
   function automatic logic [6:0] chip_tenths(input logic [3:0] c);
      case (c)
         4'h0:    return 7'd10;
         4'h1:    return 7'd20;
         4'h2:    return 7'd25;
         4'h3:    return 7'd26;
         4'h4:    return 7'd26;
         4'h5:    return 7'd27;
         4'h6:    return 7'd28;
         4'h7:    return 7'd29;
         4'h8:    return 7'd30;
         4'h9:    return 7'd31;
         4'ha:    return 7'd32;
         4'hb:    return 7'd33;
         4'hc:    return 7'd35;
         4'hd:    return 7'd40;
         4'he:    return 7'd45;
         default: return 7'd50;
      endcase
   endfunction : chip_tenths

   // Rotate-and-xor fold; catches any single flipped bit in the array
   function automatic logic [7:0] fold_sig(input logic [4:0] t, input logic [1:0] d,
                                           input logic [7:0] o, input logic [7:0] l0,
                                           input logic [7:0] h0, input logic [7:0] l1,
                                           input logic [7:0] h1);
      logic [7:0] s;
      s = {3'h0, t};
      s = {s[6:0], s[7]} ^ {6'h00, d};
      s = {s[6:0], s[7]} ^ o;
      s = {s[6:0], s[7]} ^ l0;
      s = {s[6:0], s[7]} ^ h0;
      s = {s[6:0], s[7]} ^ l1;
      s = {s[6:0], s[7]} ^ h1;
      return s;
   endfunction : fold_sig

   assign access_open = !psi5_mode || psi5_diag_mode; // RULE18
   assign do_write    = reg_req.wr && addr_mapped && access_open; // RULE18
   assign code        = timing_config_reg[3:0];

   // Address decode; reserved bits read as zero
   always_comb begin
      addr_mapped = 1'b1;
      read_value  = 8'h00;
      if (reg_req.addr == `OFS_TIMING_CONFIG) begin
         read_value = {3'h0, timing_config_reg};
      end else if (reg_req.addr == `OFS_DIAG_MODE_CONFIG) begin
         read_value = {6'h00, diag_mode_config_reg};
      end else if (reg_req.addr == `OFS_BUS_OPTION_CONFIG) begin
         read_value = bus_option_config_reg;
      end else if (reg_req.addr == `OFS_SLOT0_START_LOW) begin
         read_value = slot0_start_low_reg;
      end else if (reg_req.addr == `OFS_SLOT0_START_HIGH) begin
         read_value = slot0_start_high_reg;
      end else if (reg_req.addr == `OFS_SLOT1_START_LOW) begin
         read_value = slot1_start_low_reg;
      end else if (reg_req.addr == `OFS_SLOT1_START_HIGH) begin
         read_value = slot1_start_high_reg;
      end else begin
         addr_mapped = 1'b0;
      end
   end

   // Register writes; reserved bits are not stored
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         timing_config_reg     <= 5'h00;
         diag_mode_config_reg  <= 2'h0;
         bus_option_config_reg <= `REG_RESET;
         slot0_start_low_reg   <= `REG_RESET;
         slot0_start_high_reg  <= `REG_RESET;
         slot1_start_low_reg   <= `REG_RESET;
         slot1_start_high_reg  <= `REG_RESET;
      end else if (do_write) begin // RULE18
         if (reg_req.addr == `OFS_TIMING_CONFIG) begin
            timing_config_reg <= reg_req.wdata[4:0]; // RULE21
         end else if (reg_req.addr == `OFS_DIAG_MODE_CONFIG) begin
            diag_mode_config_reg <= reg_req.wdata[1:0];
         end else if (reg_req.addr == `OFS_BUS_OPTION_CONFIG) begin
            bus_option_config_reg <= reg_req.wdata;
         end else if (reg_req.addr == `OFS_SLOT0_START_LOW) begin
            slot0_start_low_reg <= reg_req.wdata;
         end else if (reg_req.addr == `OFS_SLOT0_START_HIGH) begin
            slot0_start_high_reg <= {reg_req.wdata[7:6], 1'b0, reg_req.wdata[4:0]};
         end else if (reg_req.addr == `OFS_SLOT1_START_LOW) begin
            slot1_start_low_reg <= reg_req.wdata;
         end else if (reg_req.addr == `OFS_SLOT1_START_HIGH) begin
            slot1_start_high_reg <= {reg_req.wdata[7:6], 1'b0, reg_req.wdata[4:0]};
         end
      end
   end

   // Answer one cycle after the request
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rsp <= '0;
      end else begin
         reg_rsp.ack     <= (reg_req.wr || reg_req.rd) && addr_mapped && access_open;
         reg_rsp.refused <= (reg_req.wr || reg_req.rd) && addr_mapped && !access_open; // RULE18
         reg_rsp.rdata   <= (reg_req.rd && addr_mapped && access_open) ? read_value : 8'h00;
      end
   end

   // Reference signature follows every legal write
   assign signature_next = fold_sig(timing_config_reg, diag_mode_config_reg,
                                    bus_option_config_reg, slot0_start_low_reg,
                                    slot0_start_high_reg, slot1_start_low_reg,
                                    slot1_start_high_reg);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         signature_reg  <= 8'h00;
         write_prev_reg <= 1'b0;
         array_error    <= 1'b0;
      end else begin
         signature_reg  <= signature_next; // RULE19
         // Legal write one cycle back moves the signature on purpose
         write_prev_reg <= do_write;
         // Sticky until reset, so a transient upset is not missed
         if (!do_write && !write_prev_reg && signature_reg != signature_next) begin
            array_error <= 1'b1; // RULE19
         end
      end
   end

   // Pulldown engages on the first sync pulse after the option is set
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_pulldown_on <= 1'b0;
      end else if (!psi5_mode || !bus_option_config_reg[`OPT_SYNC_PULLDOWN_BIT]) begin
         sync_pulldown_on <= 1'b0; // RULE6
      end else if (sync_pulse_seen) begin
         sync_pulldown_on <= 1'b1; // RULE6
      end
   end

   // Settings seen by the transmitter, one cycle behind the registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         settings <= '0;
      end else begin
         settings.latency_from_sync <= psi5_mode && timing_config_reg[`TIMING_SAMPLING_BIT]; // RULE1
         settings.bit_rate_slow     <= psi5_mode && code[3]; // RULE2
         settings.bit_period_tenths <= code[3] ? 7'(`PSI5_PERIOD_SLOW_TENTHS)
                                               : 7'(`PSI5_PERIOD_FAST_TENTHS); // RULE2
         settings.chip_time_tenths  <= chip_tenths(code); // RULE3
         settings.slew_enable       <= psi5_mode || (code > 4'h1); // RULE2 RULE3
         settings.diag_active       <= !psi5_mode
                                       && diag_mode_config_reg[`DIAG_ENABLE_BIT]; // RULE5
         settings.diag_cmd_bits     <= diag_mode_config_reg[`DIAG_FRAGMENT_BIT]
                                       ? `DIAG_CMD_BITS_LONG : `DIAG_CMD_BITS_SHORT; // RULE4
         settings.diag_rsp_chips    <= diag_mode_config_reg[`DIAG_FRAGMENT_BIT]
                                       ? `DIAG_RSP_CHIPS_LONG : `DIAG_RSP_CHIPS_SHORT; // RULE4
         settings.daisy_chain_mode  <= psi5_mode
                                       && bus_option_config_reg[`OPT_DAISY_CHAIN_BIT]; // RULE7
         settings.reduced_current   <= psi5_mode
                                       && bus_option_config_reg[`OPT_REDUCED_CURR_BIT]; // RULE8
         settings.clip_low          <= bus_option_config_reg[`OPT_RANGE_WIDEN_BIT]
                                       ? 10'(`CLIP_WIDE_LOW) : 10'(`CLIP_NARROW_LOW); // RULE9
         settings.clip_high         <= bus_option_config_reg[`OPT_RANGE_WIDEN_BIT]
                                       ? 10'(`CLIP_WIDE_HIGH) : 10'(`CLIP_NARROW_HIGH); // RULE9
         settings.error_detail      <= bus_option_config_reg[`OPT_ERROR_DETAIL_BIT]; // RULE10
         settings.error_code        <= `SINGLE_ERROR_CODE; // RULE10
         settings.crc_check         <= psi5_mode
                                       && bus_option_config_reg[`OPT_CRC_SELECT_BIT]; // RULE11
         settings.phase2_extension  <= psi5_mode
                                       && bus_option_config_reg[`OPT_PHASE2_EXT_BIT]; // RULE12
         settings.free_running      <= psi5_mode
                                       && bus_option_config_reg[`OPT_FREE_RUNNING_BIT]
                                       && !bus_option_config_reg[`OPT_DAISY_CHAIN_BIT]; // RULE13
      end
   end

   // Source 0 carries the first result, source 1 the second
   slot_timing u_slot0 (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .start_low  (slot0_start_low_reg),
      .start_high (slot0_start_high_reg),
      .timing     (slot0_timing)
   ); // RULE16 RULE7

   slot_timing u_slot1 (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .start_low  (slot1_start_low_reg),
      .start_high (slot1_start_high_reg),
      .timing     (slot1_timing)
   ); // RULE16

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   locked_refused_a: assert property ( // RULE18
      (reg_req.wr && addr_mapped && psi5_mode && !psi5_diag_mode)
      |=> (reg_rsp.refused && !reg_rsp.ack && $stable(bus_option_config_reg)
           || !$past(reg_req.addr == `OFS_BUS_OPTION_CONFIG) && reg_rsp.refused))
      else $error("locked write was not refused");

   write_lands_a: assert property ( // RULE18
      (reg_req.wr && access_open && reg_req.addr == `OFS_SLOT0_START_LOW)
      |=> (slot0_start_low_reg == $past(reg_req.wdata)) ##2
          (u_slot0.raw_start[7:0] == slot0_start_low_reg || $past(do_write, 2)))
      else $error("allowed write did not land");

   rate_select_a: assert property ( // RULE2
      settings.bit_rate_slow == ($past(psi5_mode) && $past(timing_config_reg[3])))
      else $error("bit rate does not follow timing code");

   chip_slew_a: assert property ( // RULE3
      !$past(psi5_mode) |-> (settings.slew_enable == ($past(code) > 4'h1)))
      else $error("slew control wrong for chip time");

   diag_psi5_a: assert property ( // RULE5
      psi5_mode [*2] |-> !settings.diag_active)
      else $error("diagnostic mode active in PSI5");

   free_run_a: assert property ( // RULE13
      settings.free_running |-> !settings.daisy_chain_mode)
      else $error("free running with daisy chain");

   pulldown_gate_a: assert property ( // RULE6
      (!psi5_mode || !bus_option_config_reg[`OPT_SYNC_PULLDOWN_BIT]) |=> !sync_pulldown_on)
      else $error("pulldown engaged while disabled");

   clip_range_a: assert property ( // RULE9
      $past(rst_n) |->
      settings.clip_high == ($past(bus_option_config_reg[`OPT_RANGE_WIDEN_BIT])
                             ? 10'sd480 : 10'sd307))
      else $error("clip limit wrong");

   start_floor_a: assert property ( // RULE14
      $past(rst_n) |->
      (slot0_timing.start_us >= 13'd20) && (slot1_timing.start_cycles >= 17'd200))
      else $error("start time below floor");

   array_clean_a: assert property ( // RULE19
      !array_error)
      else $error("configuration array check failed");

   cover_write_c:    cover property (do_write ##1 reg_rsp.ack);
   cover_refused_c:  cover property (reg_rsp.refused);
   cover_pulldown_c: cover property (!sync_pulldown_on ##1 sync_pulldown_on);
   cover_freerun_c:  cover property (settings.free_running);

endmodule : sensor_bus_protocol_config

// >>> hdl/sensor_cfg_params.svh
// Offsets, field positions, reset values and timing counts of the protocol configuration group
`ifndef SENSOR_CFG_PARAMS_SVH
`define SENSOR_CFG_PARAMS_SVH

`define OFS_TIMING_CONFIG      8'h23
`define OFS_DIAG_MODE_CONFIG   8'h24
`define OFS_BUS_OPTION_CONFIG  8'h25
`define OFS_SLOT0_START_LOW    8'h26
`define OFS_SLOT0_START_HIGH   8'h27
`define OFS_SLOT1_START_LOW    8'h28
`define OFS_SLOT1_START_HIGH   8'h29

`define REG_RESET              8'h00

`define TIMING_SAMPLING_BIT    4
`define DIAG_FRAGMENT_BIT      1
`define DIAG_ENABLE_BIT        0
`define OPT_SYNC_PULLDOWN_BIT  7
`define OPT_DAISY_CHAIN_BIT    6
`define OPT_REDUCED_CURR_BIT   5
`define OPT_RANGE_WIDEN_BIT    4
`define OPT_ERROR_DETAIL_BIT   3
`define OPT_CRC_SELECT_BIT     2
`define OPT_PHASE2_EXT_BIT     1
`define OPT_FREE_RUNNING_BIT   0
`define HIGH_BRC_MSB           7
`define HIGH_BRC_LSB           6
`define HIGH_START_MSB         4

`define START_STEP_NS          1000
`define CLK_PERIOD_NS          100
`define START_FLOOR_US         20
`define PSI5_PERIOD_FAST_TENTHS 53
`define PSI5_PERIOD_SLOW_TENTHS 80
`define CLIP_NARROW_LOW        (-102)
`define CLIP_NARROW_HIGH       307
`define CLIP_WIDE_LOW          (-480)
`define CLIP_WIDE_HIGH         480
`define SINGLE_ERROR_CODE      10'h1f4
`define DIAG_CMD_BITS_SHORT    3'h2
`define DIAG_CMD_BITS_LONG     3'h4
`define DIAG_RSP_CHIPS_SHORT   3'h3
`define DIAG_RSP_CHIPS_LONG    3'h6

`endif

// >>> hdl/sensor_cfg_pkg.sv
// Types shared by the protocol configuration group
package sensor_cfg_pkg;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic        ack;
      logic        refused;
      logic [7:0]  rdata;
   } reg_rsp_t;

   typedef struct packed {
      logic [12:0] start_us;
      logic [16:0] start_cycles;
      logic        answers_brc0;
      logic        answers_brc1;
   } slot_timing_t;

   typedef struct packed {
      logic               latency_from_sync;
      logic               bit_rate_slow;
      logic [6:0]         bit_period_tenths;
      logic [6:0]         chip_time_tenths;
      logic               slew_enable;
      logic               diag_active;
      logic [2:0]         diag_cmd_bits;
      logic [2:0]         diag_rsp_chips;
      logic               daisy_chain_mode;
      logic               reduced_current;
      logic signed [9:0]  clip_low;
      logic signed [9:0]  clip_high;
      logic               error_detail;
      logic [9:0]         error_code;
      logic               crc_check;
      logic               phase2_extension;
      logic               free_running;
   } proto_settings_t;

endpackage : sensor_cfg_pkg

// >>> hdl/slot_timing.sv
// Response start time and broadcast reply decode for one source slot
`timescale 1ns/1ps
`include "sensor_cfg_params.svh"

module slot_timing
   import sensor_cfg_pkg::*;
(
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic [7:0]   start_low,
   input  wire logic [7:0]   start_high,
   output slot_timing_t      timing
);

   localparam int unsigned CYC_PER_STEP = `START_STEP_NS / `CLK_PERIOD_NS;

   logic [12:0] raw_start;

   // Zero, small values and exactly the floor all resolve to the floor
   function automatic logic [12:0] resolve_start(input logic [12:0] v);
      if (v <= 13'(`START_FLOOR_US)) begin // RULE14 RULE15 RULE22
         return 13'(`START_FLOOR_US);
      end
      return v;
   endfunction : resolve_start

   assign raw_start = {start_high[`HIGH_START_MSB:0], start_low}; // RULE23

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         timing <= '0;
      end else begin
         timing.start_us     <= resolve_start(raw_start);
         timing.start_cycles <= 17'(resolve_start(raw_start)) * 17'(CYC_PER_STEP); // RULE14
         // Both-set and both-clear answer every broadcast read
         timing.answers_brc0 <= (start_high[`HIGH_BRC_MSB:`HIGH_BRC_LSB] != 2'b10); // RULE20
         timing.answers_brc1 <= (start_high[`HIGH_BRC_MSB:`HIGH_BRC_LSB] != 2'b01); // RULE20
      end
   end

endmodule : slot_timing

// >>> testbench/bus_master_model.sv
// Bus master model that issues register requests to the configuration group
`timescale 1ns/1ps

module bus_master_model
   import sensor_cfg_pkg::*;
(
   input  wire logic ref_clk,
   input  reg_rsp_t  reg_rsp,
   output reg_req_t  reg_req
);

   initial reg_req = '0;

   // One request per call, a free edge first so strobes never toggle twice in one step
   // Caller writes the same start values to both slots; nothing here checks for bus contention
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                         output reg_rsp_t rsp);
      @(posedge ref_clk);
      #1;
      reg_req.wr    = w;
      reg_req.rd    = ~w;
      reg_req.addr  = a;
      reg_req.wdata = d;
      @(posedge ref_clk);
      #1;
      rsp           = reg_rsp;
      reg_req.wr    = 1'b0;
      reg_req.rd    = 1'b0;
      // Released lines show the inverse, not a stale copy
      reg_req.addr  = ~a;
      reg_req.wdata = ~d;
   endtask : access

endmodule : bus_master_model

// >>> testbench/sensor_bus_protocol_config_tb.sv
// Self-checking testbench of the protocol configuration group
`timescale 1ns/1ps

module sensor_bus_protocol_config_tb;
   import sensor_cfg_pkg::*;

   logic            ref_clk = 1'b0;
   logic            rst_n = 1'b0;
   logic            psi5_mode = 1'b0;
   logic            psi5_diag_mode = 1'b0;
   logic            sync_pulse_seen = 1'b0;
   reg_req_t        reg_req;
   reg_rsp_t        reg_rsp;
   proto_settings_t settings;
   slot_timing_t    slot0_timing;
   slot_timing_t    slot1_timing;
   logic            sync_pulldown_on;
   logic            array_error;
   int              n_mismatch = 0;
   int              num_checks = 0;
   logic [6:0]      chip_tab [16] = '{7'h0a, 7'h14, 7'h19, 7'h1a, 7'h1a, 7'h1b, 7'h1c, 7'h1d,
                                      7'h1e, 7'h1f, 7'h20, 7'h21, 7'h23, 7'h28, 7'h2d, 7'h32};
   logic [12:0]     start_in [6] = '{13'h0000, 13'h0005, 13'h0013, 13'h0014, 13'h0015, 13'h1fff};
   logic [12:0]     start_exp [6] = '{13'h0014, 13'h0014, 13'h0014, 13'h0014, 13'h0015, 13'h1fff};

   always #50 ref_clk = ~ref_clk;

   bus_master_model i_bus_master_model (.ref_clk(ref_clk), .reg_rsp(reg_rsp), .reg_req(reg_req));

   sensor_bus_protocol_config i_sensor_bus_protocol_config (
      .ref_clk(ref_clk), .rst_n(rst_n), .psi5_mode(psi5_mode), .psi5_diag_mode(psi5_diag_mode),
      .sync_pulse_seen(sync_pulse_seen), .reg_req(reg_req), .reg_rsp(reg_rsp),
      .settings(settings), .slot0_timing(slot0_timing), .slot1_timing(slot1_timing),
      .sync_pulldown_on(sync_pulldown_on), .array_error(array_error));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic refd);
      reg_rsp_t r;
      i_bus_master_model.access(1'b1, a, d, r);
      chk({r.ack, r.refused}, {~refd, refd});
      @(posedge ref_clk);
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_rsp_t r;
      i_bus_master_model.access(1'b0, a, 8'h00, r);
      chk({r.ack, r.refused, r.rdata}, {2'b10, exp});
   endtask : rd

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   initial begin
      #300000;
      n_mismatch++;
      print_verdict();
   end

   initial begin
      reg_rsp_t r;
      repeat (4) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      @(posedge ref_clk);
      #1;
      for (int a = 8'h23; a <= 8'h29; a++) rd(8'(a), 8'h00);
      chk({settings.clip_low, settings.clip_high}, {10'h39a, 10'h133});
      chk({settings.diag_cmd_bits, settings.diag_rsp_chips}, {3'h2, 3'h3});
      chk({settings.error_detail, settings.error_code}, {1'b0, 10'h1f4});
      chk(slot0_timing, {13'h14, 17'h0c8, 2'b11});
      chk(slot1_timing, {13'h14, 17'h0c8, 2'b11});
      $display("test reset done");
      for (int c = 0; c < 16; c++) begin
         wr(8'h23, 8'(c), 1'b0);
         chk({settings.chip_time_tenths, settings.slew_enable}, {chip_tab[c], c > 1});
      end
      wr(8'h24, 8'hff, 1'b0);
      rd(8'h24, 8'h03);
      chk({settings.diag_active, settings.diag_cmd_bits, settings.diag_rsp_chips}, 7'h66);
      wr(8'h25, 8'h07, 1'b0);
      chk({settings.crc_check, settings.phase2_extension, settings.free_running}, 3'h0);
      $display("test dsi3 done");
      psi5_mode = 1'b1;
      psi5_diag_mode = 1'b1;
      for (int c = 0; c < 16; c++) begin
         wr(8'h23, {3'h0, 1'(c), 4'(c)}, 1'b0);
         chk({settings.latency_from_sync, settings.bit_rate_slow, settings.slew_enable},
             {1'(c), c > 7, 1'b1});
         chk(settings.bit_period_tenths, (c > 7) ? 7'h50 : 7'h35);
      end
      wr(8'h23, 8'hff, 1'b0);
      rd(8'h23, 8'h1f);
      chk(settings.diag_active, 1'b0);
      wr(8'h25, 8'h7e, 1'b0);
      chk({settings.daisy_chain_mode, settings.reduced_current, settings.clip_low,
           settings.clip_high}, {2'b11, 10'h220, 10'h1e0});
      chk({settings.error_detail, settings.crc_check, settings.phase2_extension,
           settings.free_running}, 4'he);
      wr(8'h25, 8'h41, 1'b0);
      chk({settings.daisy_chain_mode, settings.free_running}, 2'b10);
      wr(8'h25, 8'h81, 1'b0);
      chk({settings.daisy_chain_mode, settings.free_running, sync_pulldown_on}, 3'b010);
      sync_pulse_seen = 1'b1;
      @(posedge ref_clk);
      #1;
      sync_pulse_seen = 1'b0;
      chk(sync_pulldown_on, 1'b1);
      psi5_diag_mode = 1'b0;
      i_bus_master_model.access(1'b1, 8'h25, 8'h00, r);
      chk({r.ack, r.refused}, 2'b01);
      i_bus_master_model.access(1'b0, 8'h30, 8'h00, r);
      chk({r.ack, r.refused}, 2'b00);
      psi5_mode = 1'b0;
      @(posedge ref_clk);
      #1;
      chk(sync_pulldown_on, 1'b0);
      rd(8'h25, 8'h81);
      $display("test psi5 done");
      for (int i = 0; i < 6; i++) begin
         wr(8'h26, start_in[i][7:0], 1'b0);
         wr(8'h27, {2'(i), 1'b1, start_in[i][12:8]}, 1'b0);
         wr(8'h28, start_in[i][7:0], 1'b0);
         wr(8'h29, {~2'(i), 1'b0, start_in[i][12:8]}, 1'b0);
         rd(8'h27, {2'(i), 1'b0, start_in[i][12:8]});
         chk({slot0_timing.start_us, slot0_timing.start_cycles},
             {start_exp[i], 17'(start_exp[i] * 10)});
         chk(slot1_timing.start_us, start_exp[i]);
         chk({slot0_timing.answers_brc0, slot0_timing.answers_brc1},
             {2'(i) != 2'd2, 2'(i) != 2'd1});
         // Two-bit operands keep the inversion from spreading to 32 bits
         chk({slot1_timing.answers_brc0, slot1_timing.answers_brc1},
             {~2'(i) != 2'd2, ~2'(i) != 2'd1});
      end
      chk(array_error, 1'b0);
      $display("test start times done");
      print_verdict();
   end

endmodule : sensor_bus_protocol_config_tb
